//--- clkc_pkg.sv
// constants for the clock gating and alignment reference control block
// assumes a single 10 MHz system clock and a slow serial configuration port
`default_nettype none
package clkc_pkg;
  localparam int unsigned ADDR_W    = 15;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned INSTR_W   = 16;
  localparam int unsigned CNT_W     = 5;
  localparam logic [CNT_W-1:0] INSTR_LAST = 5'h0f;
  localparam logic [CNT_W-1:0] DATA_LAST  = 5'h07;

  // register offsets
  localparam logic [ADDR_W-1:0] CLK_CFG_ADDR   = 15'h0080;
  localparam logic [ADDR_W-1:0] ALIGN_CTL_ADDR = 15'h0081;

  // clock gating configuration fields
  localparam int unsigned ALL_CH_PD_BIT  = 5;
  localparam int unsigned CAL_PD_BIT     = 4;
  localparam int unsigned CLK_RX_PD_BIT  = 3;
  localparam int unsigned DUTY_EN_BIT    = 2;
  localparam int unsigned RF_ALIGN_BIT   = 1;
  localparam int unsigned RF_DIV2_BIT    = 0;
  localparam logic [DATA_W-1:0] CLK_CFG_RST  = 8'h3e;
  localparam logic [DATA_W-1:0] CLK_CFG_MASK = 8'h3f;

  // alignment reference receiver control fields
  localparam int unsigned ALIGN_PD_BIT   = 4;
  localparam int unsigned HYST_EN_BIT    = 3;
  localparam int unsigned EDGE_SEL_BIT   = 2;
  localparam logic [DATA_W-1:0] ALIGN_RST  = 8'h10;
  localparam logic [DATA_W-1:0] ALIGN_MASK = 8'h1c;

  // serial port sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_INSTR = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_DONE  = 4'b1000
  } clkc_state_t;
endpackage
`default_nettype wire

//--- clkc_cfg_if.sv
// register access carrier between the serial port and the register file
// assumes both ends run on the system clock
`timescale 1ns/1ns
`default_nettype none
interface clkc_cfg_if;
  import clkc_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr_stb;
  logic [DATA_W-1:0] rdata;
  modport port_side (output addr, output wdata, output wr_stb, input rdata);
  modport reg_side  (input addr, input wdata, input wr_stb, output rdata);
endinterface
`default_nettype wire

//--- clkc_spi_slave.sv
// serial configuration port: 16-bit instruction, one data byte, msb first
// assumes sclk is at most a quarter of the system clock, sampled on its rising edge
`timescale 1ns/1ns
`default_nettype none
module clkc_spi_slave
  import clkc_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        nrst_in,
  input  wire logic        sclk_in,
  input  wire logic        csb_n_in,
  input  wire logic        sdi_in,
  output logic             sdo_out,
  output logic             sdo_oe_out,
  clkc_cfg_if.port_side    bus
);
  logic [2:0]        sclk_q;
  logic [1:0]        csb_n_q, sdi_q;
  clkc_state_t       state_q, state_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [INSTR_W-1:0] sh_q, sh_d;
  logic              rd_q, rd_d, load_q, load_d, wr_q, wr_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [DATA_W-1:0] wdat_q, wdat_d, tx_q, tx_d;
  logic              sdo_q, sdo_d, oe_q, oe_d;
  logic              rise, fall;
  logic [INSTR_W-1:0] sh_in;

  // pin synchronisers; only stages past the first are looked at
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sclk_q  <= 3'h0;
      csb_n_q <= 2'h3;
      sdi_q   <= 2'h0;
    end else begin
      sclk_q  <= {sclk_q[1:0], sclk_in};
      csb_n_q <= {csb_n_q[0], csb_n_in};
      sdi_q   <= {sdi_q[0], sdi_in};
    end
  end

  assign rise  = sclk_q[1] & ~sclk_q[2];
  assign fall  = ~sclk_q[1] & sclk_q[2];
  assign sh_in = {sh_q[INSTR_W-2:0], sdi_q[1]};

  // sequencer next state; write strobe only after the last data bit
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    rd_d    = rd_q;
    addr_d  = addr_q;
    wdat_d  = wdat_q;
    wr_d    = 1'b0;
    load_d  = 1'b0;
    tx_d    = tx_q;
    sdo_d   = sdo_q;
    oe_d    = oe_q;
    if (load_q) begin
      tx_d = bus.rdata;
    end
    case (state_q)
      ST_IDLE: begin
        cnt_d = '0;
        oe_d  = 1'b0;
        if (!csb_n_q[1]) begin
          state_d = ST_INSTR;
        end
      end
      ST_INSTR: begin
        if (rise) begin
          sh_d  = sh_in;
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == INSTR_LAST) begin
            rd_d    = sh_in[INSTR_W-1];
            addr_d  = sh_in[ADDR_W-1:0];
            load_d  = sh_in[INSTR_W-1];
            cnt_d   = '0;
            state_d = ST_DATA;
          end
        end
      end
      ST_DATA: begin
        oe_d = rd_q;
        if (fall && rd_q) begin
          sdo_d = tx_q[DATA_W-1];
          tx_d  = {tx_q[DATA_W-2:0], 1'b0};
        end
        if (rise) begin
          sh_d  = sh_in;
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == DATA_LAST) begin
            wdat_d  = sh_in[DATA_W-1:0];
            wr_d    = ~rd_q;
            state_d = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        // one byte per frame; extra clocks are ignored until deselect
        if (fall && rd_q) begin
          oe_d = 1'b0;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (csb_n_q[1]) begin
      state_d = ST_IDLE;
      oe_d    = 1'b0;
      wr_d    = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
      sh_q    <= '0;
      rd_q    <= 1'b0;
      load_q  <= 1'b0;
      wr_q    <= 1'b0;
      addr_q  <= '0;
      wdat_q  <= '0;
      tx_q    <= '0;
      sdo_q   <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      rd_q    <= rd_d;
      load_q  <= load_d;
      wr_q    <= wr_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
      tx_q    <= tx_d;
      sdo_q   <= sdo_d;
      oe_q    <= oe_d;
    end
  end

  assign bus.addr   = addr_q;
  assign bus.wdata  = wdat_q;
  assign bus.wr_stb = wr_q;
  assign sdo_out    = sdo_q;
  assign sdo_oe_out = oe_q;
endmodule
`default_nettype wire

//--- clkc_clock_ctrl.sv
// clock gating and alignment reference control registers with their effects
// assumes a host on the serial configuration port and a raw reference pin
`timescale 1ns/1ns
`default_nettype none
module clkc_clock_ctrl
  import clkc_pkg::*;
(
  input  wire logic sys_clk_in,
  input  wire logic nrst_in,
  input  wire logic sclk_in,
  input  wire logic csb_n_in,
  input  wire logic sdi_in,
  input  wire logic align_ref_in,
  output logic      sdo_out,
  output logic      sdo_oe_out,
  output logic      all_channel_clock_powerdown_out,
  output logic      calibration_clock_powerdown_out,
  output logic      clock_receiver_powerdown_out,
  output logic      duty_cycle_enable_out,
  output logic      rf_chain_alignment_enable_out,
  output logic      rf_divide_by_two_enable_out,
  output logic      alignment_receiver_powerdown_out,
  output logic      hysteresis_enable_out,
  output logic      alignment_edge_select_out,
  output logic      sample_clk_en_out,
  output logic      calibration_clk_en_out,
  output logic      hysteresis_active_out,
  output logic      align_strobe_out
);
  clkc_cfg_if bus ();

  logic [DATA_W-1:0] clk_cfg_q, clk_cfg_d, align_q, align_d;
  logic [2:0]        ref_q;
  logic              div_q, div_d, smp_q, smp_d, cal_q, cal_d;
  logic              hys_q, hys_d, stb_q, stb_d;
  logic              ref_rise, ref_fall, rx_on;

  // address match, shared by read and write paths
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] r);
    hit = (a == r);
  endfunction

  clkc_spi_slave u_port (
    .sys_clk_in (sys_clk_in),
    .nrst_in    (nrst_in),
    .sclk_in    (sclk_in),
    .csb_n_in   (csb_n_in),
    .sdi_in     (sdi_in),
    .sdo_out    (sdo_out),
    .sdo_oe_out (sdo_oe_out),
    .bus        (bus.port_side)
  );

  // readback; unmapped addresses and left-out bits read zero
  always_comb begin
    if (hit(bus.addr, CLK_CFG_ADDR)) begin
      bus.rdata = clk_cfg_q & CLK_CFG_MASK;
    end else if (hit(bus.addr, ALIGN_CTL_ADDR)) begin
      bus.rdata = align_q & ALIGN_MASK;
    end else begin
      bus.rdata = '0;
    end
  end

  // register writes land only on the completed-byte strobe
  always_comb begin
    clk_cfg_d = clk_cfg_q;
    align_d   = align_q;
    if (bus.wr_stb && hit(bus.addr, CLK_CFG_ADDR)) begin
      clk_cfg_d = bus.wdata & CLK_CFG_MASK;
    end
    if (bus.wr_stb && hit(bus.addr, ALIGN_CTL_ADDR)) begin
      align_d = bus.wdata & ALIGN_MASK;
    end
  end

  // duty-cycle bit is stored as written; software must leave it at 1
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clk_cfg_q <= CLK_CFG_RST;
      align_q   <= ALIGN_RST;
    end else begin
      clk_cfg_q <= clk_cfg_d;
      align_q   <= align_d;
    end
  end

  // reference pin synchroniser and edge detect on the later stages
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ref_q <= 3'h0;
    end else begin
      ref_q <= {ref_q[1:0], align_ref_in};
    end
  end

  assign ref_rise = ref_q[1] & ~ref_q[2];
  assign ref_fall = ~ref_q[1] & ref_q[2];
  assign rx_on    = ~align_q[ALIGN_PD_BIT];

  // derived clock enables and alignment strobe
  always_comb begin
    div_d = 1'b0;
    smp_d = 1'b0;
    if (!clk_cfg_q[ALL_CH_PD_BIT] && !clk_cfg_q[CLK_RX_PD_BIT]) begin
      if (clk_cfg_q[RF_DIV2_BIT]) begin
        div_d = ~div_q;
        smp_d = div_q;
      end else begin
        smp_d = 1'b1;
      end
    end
    cal_d = ~clk_cfg_q[CAL_PD_BIT] & ~clk_cfg_q[CLK_RX_PD_BIT];
    hys_d = rx_on & align_q[HYST_EN_BIT];
    // a powered-down receiver sees no edges, so no strobe is raised
    stb_d = 1'b0;
    if (rx_on && clk_cfg_q[RF_ALIGN_BIT]) begin
      stb_d = align_q[EDGE_SEL_BIT] ? ref_rise : ref_fall;
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      div_q <= 1'b0;
      smp_q <= 1'b0;
      cal_q <= 1'b0;
      hys_q <= 1'b0;
      stb_q <= 1'b0;
    end else begin
      div_q <= div_d;
      smp_q <= smp_d;
      cal_q <= cal_d;
      hys_q <= hys_d;
      stb_q <= stb_d;
    end
  end

  // control bits leave straight from the register flops
  assign all_channel_clock_powerdown_out  = clk_cfg_q[ALL_CH_PD_BIT];
  assign calibration_clock_powerdown_out  = clk_cfg_q[CAL_PD_BIT];
  assign clock_receiver_powerdown_out     = clk_cfg_q[CLK_RX_PD_BIT];
  assign duty_cycle_enable_out            = clk_cfg_q[DUTY_EN_BIT];
  assign rf_chain_alignment_enable_out    = clk_cfg_q[RF_ALIGN_BIT];
  assign rf_divide_by_two_enable_out      = clk_cfg_q[RF_DIV2_BIT];
  assign alignment_receiver_powerdown_out = align_q[ALIGN_PD_BIT];
  assign hysteresis_enable_out            = align_q[HYST_EN_BIT];
  assign alignment_edge_select_out        = align_q[EDGE_SEL_BIT];
  assign sample_clk_en_out                = smp_q;
  assign calibration_clk_en_out           = cal_q;
  assign hysteresis_active_out            = hys_q;
  assign align_strobe_out                 = stb_q;
endmodule
`default_nettype wire

//--- clkc_ctrl_monitor.sv
// port checker for the clock gating and alignment control block
// assumes it is bound onto clkc_clock_ctrl, one system clock domain
`timescale 1ns/1ns
`default_nettype none
module clkc_ctrl_monitor (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic csb_n_in,
  input wire logic align_ref_in,
  input wire logic all_channel_clock_powerdown_out,
  input wire logic calibration_clock_powerdown_out,
  input wire logic clock_receiver_powerdown_out,
  input wire logic duty_cycle_enable_out,
  input wire logic rf_chain_alignment_enable_out,
  input wire logic rf_divide_by_two_enable_out,
  input wire logic alignment_receiver_powerdown_out,
  input wire logic hysteresis_enable_out,
  input wire logic alignment_edge_select_out,
  input wire logic sample_clk_en_out,
  input wire logic calibration_clk_en_out,
  input wire logic hysteresis_active_out,
  input wire logic align_strobe_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  logic [3:0] idle_q;
  logic [3:0] idle_d;
  logic [8:0] regs_w;
  // all control bits in one vector, so any change is seen
  assign regs_w = {all_channel_clock_powerdown_out, calibration_clock_powerdown_out,
                   clock_receiver_powerdown_out, duty_cycle_enable_out,
                   rf_chain_alignment_enable_out, rf_divide_by_two_enable_out,
                   alignment_receiver_powerdown_out, hysteresis_enable_out,
                   alignment_edge_select_out};
  // cycles since select was low; saturates so it never wraps to look busy
  always_comb idle_d = !csb_n_in ? 4'h0 : (idle_q == 4'hf ? idle_q : idle_q + 4'h1);
  always_ff @(posedge sys_clk_in or negedge nrst_in)
    if (!nrst_in)
      idle_q <= 4'hf;
    else
      idle_q <= idle_d;
  property p_samp_off;
    all_channel_clock_powerdown_out || clock_receiver_powerdown_out |=> !sample_clk_en_out;
  endproperty
  a_samp_off: assert property (p_samp_off) else $error("sample enable while off");
  property p_full_rate;
    !all_channel_clock_powerdown_out && !clock_receiver_powerdown_out
      && !rf_divide_by_two_enable_out |=> sample_clk_en_out;
  endproperty
  a_full_rate: assert property (p_full_rate) else $error("sample enable missing");
  property p_half_rate;
    sample_clk_en_out && rf_divide_by_two_enable_out && $past(rf_divide_by_two_enable_out)
      |=> !sample_clk_en_out;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("divider not halving");
  property p_cal_clk;
    1'b1 |=> calibration_clk_en_out == ($past(!calibration_clock_powerdown_out)
      && $past(!clock_receiver_powerdown_out));
  endproperty
  a_cal_clk: assert property (p_cal_clk) else $error("calibration enable wrong");
  property p_hyst;
    1'b1 |=> hysteresis_active_out == ($past(hysteresis_enable_out)
      && $past(!alignment_receiver_powerdown_out));
  endproperty
  a_hyst: assert property (p_hyst) else $error("hysteresis state wrong");
  property p_strobe_gate;
    align_strobe_out |-> $past(!alignment_receiver_powerdown_out)
      && $past(rf_chain_alignment_enable_out);
  endproperty
  a_strobe_gate: assert property (p_strobe_gate) else $error("strobe while gated");
  property p_strobe_edge;
    // pin level three and four samples back bracket the synchronised edge
    align_strobe_out |-> $past(align_ref_in, 3) == $past(alignment_edge_select_out)
      && $past(align_ref_in, 4) != $past(alignment_edge_select_out);
  endproperty
  a_strobe_edge: assert property (p_strobe_edge) else $error("strobe on wrong edge");
  property p_strobe_pulse;
    align_strobe_out |=> !align_strobe_out [*2];
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
  property p_write_only;
    $changed(regs_w) |-> idle_q < 4'hc;
  endproperty
  a_write_only: assert property (p_write_only) else $error("bits changed without frame");
  c_half: cover property (sample_clk_en_out && rf_divide_by_two_enable_out);
  c_rise: cover property (align_strobe_out && alignment_edge_select_out);
  c_fall: cover property (align_strobe_out && !alignment_edge_select_out);
endmodule
bind clkc_clock_ctrl clkc_ctrl_monitor i_mon (.*);
`default_nettype wire

//--- tb_top.sv
// self-checking bench for the clock gating and alignment control block
// assumes the bench drives the serial port and reference pin directly
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import clkc_pkg::*;
  logic sys_clk_in, nrst_in, sclk_in, csb_n_in, sdi_in, align_ref_in, sdo_out, sdo_oe_out;
  logic all_channel_clock_powerdown_out, calibration_clock_powerdown_out;
  logic clock_receiver_powerdown_out, duty_cycle_enable_out, rf_chain_alignment_enable_out;
  logic rf_divide_by_two_enable_out, alignment_receiver_powerdown_out, hysteresis_enable_out;
  logic alignment_edge_select_out, sample_clk_en_out, calibration_clk_en_out;
  logic hysteresis_active_out, align_strobe_out;
  int         failures, compares, strobes, seed;
  logic [7:0] exp_q [$];
  clkc_clock_ctrl i_dut (.*);
  initial begin
    sys_clk_in = 1'b0;
    forever #50 sys_clk_in = ~sys_clk_in;
  end
  // strobe tally for the edge tests
  always @(posedge sys_clk_in)
    if (align_strobe_out === 1'b1)
      strobes++;
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // control pins against the register values written
  task automatic outs(input logic [7:0] c, input logic [7:0] a);
    chk(c, {2'h0, all_channel_clock_powerdown_out, calibration_clock_powerdown_out,
            clock_receiver_powerdown_out, duty_cycle_enable_out,
            rf_chain_alignment_enable_out, rf_divide_by_two_enable_out});
    chk(a, {3'h0, alignment_receiver_powerdown_out, hysteresis_enable_out,
            alignment_edge_select_out, 2'h0});
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask
  // sclk high four cycles, low four: well above the two-flop sync need
  task automatic xfer(input logic r, input logic [14:0] a, input logic [7:0] d);
    logic [23:0] sh;
    sh = {r, a, d};
    csb_n_in = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdi_in = (r && i < 8) ? 1'($random(seed)) : sh[i];
      w(2);
      sclk_in = 1'b1;
      w(4);
      sclk_in = 1'b0;
      w(2);
    end
    w(2);
    csb_n_in = 1'b1;
    w(4);
  endtask
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    xfer(1'b0, a, d);
  endtask
  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    xfer(1'b1, a, 8'h00);
  endtask
  // enabled sample cycles out of ten
  task automatic rate(input logic [7:0] e);
    int c;
    c = 0;
    repeat (10) begin
      w(1);
      c += (sample_clk_en_out === 1'b1);
    end
    chk(e, 8'(c));
  endtask
  task automatic cfg(input logic [7:0] d, input logic [7:0] r, input logic c);
    wr(CLK_CFG_ADDR, d);
    rate(r);
    chk({7'h0, c}, {7'h0, calibration_clk_en_out});
  endtask
  // three falls and two rises, each level held ten cycles
  task automatic pulses(input logic [7:0] e);
    align_ref_in = 1'b1;
    w(10);
    strobes = 0;
    for (int i = 0; i < 5; i++) begin
      align_ref_in = ~align_ref_in;
      w(10);
    end
    chk(e, 8'(strobes));
  endtask
  // read data byte is taken at sclk rises 17 to 24
  initial begin
    logic [7:0] got;
    logic       drv;
    logic       r;
    forever begin
      @(negedge csb_n_in);
      drv = 1'b0;
      r = 1'b0;
      for (int n = 1; n <= 24; n++) begin
        @(posedge sclk_in);
        if (n == 1)
          r = sdi_in;
        if (n > 16) begin
          got = {got[6:0], sdo_out};
          drv = drv | sdo_oe_out;
        end
      end
      if (r === 1'b1) begin
        chk(exp_q.pop_front(), got);
        chk(8'h01, {7'h0, drv});
      end else begin
        chk(8'h00, {7'h0, drv});
      end
    end
  end
  task automatic results;
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // about 5500 cycles of work expected
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    failures++;
    results;
  end
  initial begin
    logic [7:0] d;
    seed = 39902;
    nrst_in = 1'b0;
    sclk_in = 1'b0;
    csb_n_in = 1'b1;
    sdi_in = 1'b0;
    align_ref_in = 1'b0;
    w(8);
    nrst_in = 1'b1;
    w(2);
    rd(CLK_CFG_ADDR, CLK_CFG_RST);
    rd(ALIGN_CTL_ADDR, ALIGN_RST);
    rate(8'h00);
    outs(CLK_CFG_RST, ALIGN_RST);
    $display("test reset done");
    repeat (3) begin
      d = 8'($random(seed));
      wr(CLK_CFG_ADDR, d | 8'h04);
      rd(CLK_CFG_ADDR, (d | 8'h04) & CLK_CFG_MASK);
      wr(ALIGN_CTL_ADDR, d);
      rd(ALIGN_CTL_ADDR, d & ALIGN_MASK);
      outs((d | 8'h04) & CLK_CFG_MASK, d & ALIGN_MASK);
    end
    wr(15'h0082, 8'hff);
    rd(15'h0082, 8'h00);
    $display("test readback done");
    cfg(8'h07, 8'h05, 1'b1);
    cfg(8'h06, 8'h0a, 1'b1);
    cfg(8'h16, 8'h0a, 1'b0);
    cfg(8'h0e, 8'h00, 1'b0);
    cfg(8'h26, 8'h00, 1'b1);
    $display("test clock gating done");
    wr(ALIGN_CTL_ADDR, 8'h08);
    chk(8'h01, {7'h0, hysteresis_active_out});
    pulses(8'h03);
    wr(ALIGN_CTL_ADDR, 8'h04);
    chk(8'h00, {7'h0, hysteresis_active_out});
    pulses(8'h02);
    wr(ALIGN_CTL_ADDR, 8'h1c);
    pulses(8'h00);
    wr(ALIGN_CTL_ADDR, 8'h04);
    wr(CLK_CFG_ADDR, 8'h24);
    pulses(8'h00);
    $display("test alignment done");
    results;
  end
endmodule
`default_nettype wire
